/* File: bench/move_return_config_decode_test.sv */
// Self-checking bench for the move/return/config decoder.
// Assumes the core and the file model are compiled alongside.
`default_nettype none
module move_return_config_decode_test;
  import mrcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic instr_valid = 1'b0;
  logic cfg_file_wr = 1'b0;
  logic [7:0] cfg_file_wdata = 8'h00;
  logic busy, stack_pop, pc_load, file_rd, global_irq_enable_set;
  logic [7:0] acc_value, cfg_value, interrupt_control_register, mask;
  logic [12:0] stack_top_entry, pc_value;
  logic [1:0] phase;
  mrcd_op_t op, op_seen;
  mrcd_file_wr_t file_wr, wr_seen;
  logic [7:0] mask_seen;
  int error_cnt = 0;
  int samples_checked = 0;
  // Pulse counts, and the clock index after the take at which each read, write, pop and enable pulse stood
  logic [15:0] n_wr, n_rd, n_pop, n_pl, n_en, n_busy, i_rd, i_wr, i_pop, i_en;
  mrcd_core uut (.clk_sys(clk_sys), .rst_b(rst_b), .instr_word(instr_word), .instr_valid(instr_valid),
    .busy(busy), .acc_value(acc_value), .stack_top_entry(stack_top_entry), .stack_pop(stack_pop),
    .pc_load(pc_load), .pc_value(pc_value), .file_wr(file_wr), .file_rd(file_rd), .cfg_file_wr(cfg_file_wr),
    .cfg_file_wdata(cfg_file_wdata), .cfg_value(cfg_value),
    .interrupt_control_register(interrupt_control_register), .global_irq_enable_set(global_irq_enable_set),
    .global_irq_enable_mask(mask), .phase(phase), .op(op));
  mrcd_file_model pm (.clk_sys(clk_sys), .file_wr(file_wr), .stack_pop(stack_pop),
    .global_irq_enable_set(global_irq_enable_set), .irq_enable_mask(mask), .acc_value(acc_value),
    .stack_top_entry(stack_top_entry), .interrupt_control_register(interrupt_control_register));
  // Clock at 250 MHz
  initial forever #2 clk_sys = ~clk_sys;
  task check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Issue one word, then log every pulse for twelve cycles after the take
  task run(input logic [13:0] w);
    {n_wr, n_rd, n_pop, n_pl, n_en, n_busy} = '0;
    {i_rd, i_wr, i_pop, i_en} = '1;
    @(negedge clk_sys);
    instr_word = w;
    instr_valid = 1'b1;
    // Index k sees what the design launched at the k-th edge after the take
    for (int k = 0; k < 12; k++) begin
      @(negedge clk_sys);
      instr_valid = 1'b0;
      if (k == 0) op_seen = op;
      if (busy) n_busy++;
      if (file_rd) begin n_rd++; i_rd = 16'(k); end
      if (file_wr.wr) begin n_wr++; i_wr = 16'(k); wr_seen = file_wr; end
      if (stack_pop) begin n_pop++; i_pop = 16'(k); end
      if (pc_load) n_pl++;
      if (global_irq_enable_set) begin n_en++; i_en = 16'(k); mask_seen = mask; end
    end
  endtask
  // One instruction cycle is four clocks: the take plus three busy clocks
  task t_reset;
    check(cfg_value, 16'h00FF);
    check(busy, 16'h0000);
    check({phase, op}, {2'd0, MRCD_OP_NONE});
    $display("reset test done");
  endtask
  task t_store;
    pm.acc_value = 8'hA5;
    run(14'h00FF);
    check(n_wr, 16'h0001);
    check(op_seen, MRCD_OP_STORE);
    check({wr_seen.addr, wr_seen.data}, {7'h7F, 8'hA5});
    check(pm.mem[7'h7F], 16'h00A5);
    check({n_rd, i_rd, i_wr}, {16'h0001, 16'h0000, 16'h0002});
    check({n_busy, n_pop, n_en}, {16'h0003, 16'h0000, 16'h0000});
    check(cfg_value, 16'h00FF);
    $display("store test done");
  endtask
  task t_idle;
    logic [13:0] w [4] = '{14'h0000, 14'h0020, 14'h0040, 14'h0060};
    foreach (w[j]) begin
      run(w[j]);
      check(n_wr + n_rd + n_pop + n_en, 16'h0000);
      check(op_seen, MRCD_OP_IDLE);
      check(n_busy, 16'h0003);
    end
    $display("idle test done");
  endtask
  task t_iret;
    pm.stk[0] = 13'h0123;
    pm.stk[1] = 13'h1ABC;
    pm.sp = 3'h1;
    pm.interrupt_control_register = 8'h15;
    run(14'h0009);
    check(op_seen, MRCD_OP_IRET);
    check({n_pop, n_pl}, {16'h0001, 16'h0001});
    check(pc_value, 16'h1ABC);
    check({n_en, mask_seen, pm.interrupt_control_register}, {16'h0001, 8'h95, 8'h95});
    check(n_busy, 16'h0007);
    check({i_en, i_pop, n_wr}, {16'h0001, 16'h0002, 16'h0000});
    $display("interrupt return test done");
  endtask
  task t_cfg;
    pm.acc_value = 8'h3C;
    run(14'h0062);
    check(cfg_value, 16'h003C);
    check(op_seen, MRCD_OP_CFG);
    check({n_busy, n_wr}, {16'h0003, 16'h0000});
    $display("legacy config test done");
  endtask
  task t_direct;
    @(negedge clk_sys);
    cfg_file_wr = 1'b1;
    cfg_file_wdata = 8'h5A;
    @(negedge clk_sys);
    cfg_file_wr = 1'b0;
    check(cfg_value, 16'h005A);
    $display("direct config test done");
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the roughly 110 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    results;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset;
    t_store;
    t_idle;
    t_iret;
    t_cfg;
    t_direct;
    results;
  end
endmodule // move_return_config_decode_test
`default_nettype wire

/* File: bench/mrcd_file_model.sv */
// Register file, hardware stack and interrupt control model for the decoder bench.
// Assumes write, pop and enable requests are one-cycle pulses on clk_sys.
`default_nettype none
module mrcd_file_model
  import mrcd_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Requests from the decoder
  input wire mrcd_file_wr_t file_wr,
  input wire logic stack_pop,
  input wire logic global_irq_enable_set,
  input wire logic [7:0] irq_enable_mask,
  // Values towards the decoder
  output logic [7:0] acc_value,
  output logic [12:0] stack_top_entry,
  output logic [7:0] interrupt_control_register
);
  logic [7:0] mem [128];
  logic [12:0] stk [8];
  logic [2:0] sp = 3'h0;
  initial begin
    acc_value = 8'h00;
    interrupt_control_register = 8'h00;
  end
  // Top entry follows the stack pointer, so a pop exposes the next entry
  assign stack_top_entry = stk[sp];
  // Accept file writes, stack pops and the enable update
  always @(posedge clk_sys) begin
    if (file_wr.wr) mem[file_wr.addr] <= file_wr.data;
    if (stack_pop) sp <= sp - 3'h1;
    if (global_irq_enable_set) interrupt_control_register <= irq_enable_mask;
  end
endmodule // mrcd_file_model
`default_nettype wire

/* File: hdl/mrcd_core.sv */
// Decoder/executor for store-accumulator, idle, interrupt-return and config-load.
// Assumes fetch presents instr_word valid at phase 1 and the file honours writes at phase 4.
//
// How it works
// RQ1: Store-accumulator copies accumulator into addressed file register, flags untouched.
// RQ2: Word 00 0000 0xx0 0000 decodes as idle, changing nothing.
// RQ3: Idle lasts one instruction cycle; decode in phase one only.
// RQ4: Interrupt return pops stack and loads popped top into program counter.
// RQ5: Interrupt return sets global enable, bit 7 of interrupt control.
// RQ6: Interrupt return takes two cycles; second cycle does nothing.
// RQ7: Legacy config-load copies accumulator into timer config in one cycle.
// RQ8: Timer config register also readable and writable as ordinary file register.
// RQ9: Software should write timer config directly, not via legacy instruction.
// RQ10: Store: decode, read target, process, write target in phase four.
// RQ11: Interrupt return sets enable in phase three, pops in phase four.
`include "mrcd_defines.svh"
`default_nettype none
module mrcd_core
  import mrcd_pkg::*;
#(
  parameter int PC_W = 13
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Fetch side
  input wire logic [13:0] instr_word,
  input wire logic instr_valid,
  output logic busy,
  // Accumulator and stack
  input wire logic [7:0] acc_value,
  input wire logic [PC_W-1:0] stack_top_entry,
  output logic stack_pop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  // Register file
  output mrcd_file_wr_t file_wr,
  output logic file_rd,
  // Direct file access to timer configuration
  input wire logic cfg_file_wr,
  input wire logic [7:0] cfg_file_wdata,
  output logic [7:0] cfg_value,
  // Interrupt control
  input wire logic [7:0] interrupt_control_register,
  output logic global_irq_enable_set,
  output logic [7:0] global_irq_enable_mask,
  // Phase and class
  output logic [1:0] phase,
  output mrcd_op_t op
);

  // Decode used for both the latch and the assertions
  function automatic mrcd_op_t decode(input logic [13:0] w);
    if ((w & `MRCD_STORE_MASK) == `MRCD_STORE_CODE) begin
      return MRCD_OP_STORE;
    end else if ((w & `MRCD_IDLE_MASK) == `MRCD_IDLE_CODE) begin
      return MRCD_OP_IDLE;
    end else if (w == `MRCD_IRET_CODE) begin
      return MRCD_OP_IRET;
    end else if (w == `MRCD_CFG_CODE) begin
      return MRCD_OP_CFG;
    end else begin
      return MRCD_OP_NONE;
    end
  endfunction

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_DEAD} mrcd_state_t;

  mrcd_state_t state_q, state_d;
  logic [1:0] phase_q, phase_d;
  mrcd_op_t op_q, op_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic [7:0] cfg_q, cfg_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic pop_q, pop_d;
  logic irq_en_q, irq_en_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;

  // Sequencer: phase count, decode at phase 1, actions per phase
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    cfg_d = cfg_q;
    pc_d = pc_q;
    pop_d = 1'b0;
    irq_en_d = 1'b0;
    wr_d = 1'b0;
    rd_d = 1'b0;
    // RQ8 direct file write
    if (cfg_file_wr) begin
      cfg_d = cfg_file_wdata;
    end
    case (state_q)
      S_IDLE: begin
        phase_d = 2'd0;
        op_d = MRCD_OP_NONE;
        // RQ2 decode idle class
        if (instr_valid) begin
          op_d = decode(instr_word);
          addr_d = instr_word[6:0];
          // RQ10 read target in phase two, two phases ahead of the write
          rd_d = (decode(instr_word) == MRCD_OP_STORE);
          state_d = S_EXEC;
          phase_d = 2'd1;
        end
      end
      S_EXEC: begin
        phase_d = phase_q + 2'd1;
        case (op_q)
          MRCD_OP_STORE: begin
            // RQ10 write follows the read
            if (phase_q == 2'd2) begin
              data_d = acc_value;
              // RQ1 write at phase four
              wr_d = 1'b1;
            end
          end
          MRCD_OP_IRET: begin
            // RQ11 enable in phase three
            if (phase_q == 2'd1) begin
              // RQ5 set global enable
              irq_en_d = 1'b1;
            end else if (phase_q == 2'd2) begin
              // RQ4 pop and load counter
              pop_d = 1'b1;
              pc_d = stack_top_entry;
            end
          end
          MRCD_OP_CFG: begin
            // RQ7 legacy config load
            if (phase_q == 2'd2) begin
              cfg_d = acc_value;
            end
          end
          default: begin
          end
        endcase
        if (phase_q == 2'd3) begin
          // RQ6 extra dead cycle; RQ3 idle ends here
          state_d = (op_q == MRCD_OP_IRET) ? S_DEAD : S_IDLE;
          phase_d = 2'd0;
        end
      end
      S_DEAD: begin
        phase_d = phase_q + 2'd1;
        if (phase_q == 2'd3) begin
          state_d = S_IDLE;
          op_d = MRCD_OP_NONE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Register the sequencer state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      phase_q <= 2'd0;
      op_q <= MRCD_OP_NONE;
      addr_q <= 7'h00;
      data_q <= 8'h00;
      cfg_q <= `MRCD_CFG_RESET;
      pc_q <= '0;
      pop_q <= 1'b0;
      irq_en_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      cfg_q <= cfg_d;
      pc_q <= pc_d;
      pop_q <= pop_d;
      irq_en_q <= irq_en_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Outputs
  assign busy = (state_q != S_IDLE);
  assign stack_pop = pop_q;
  assign pc_load = pop_q;
  assign pc_value = pc_q;
  assign file_wr = '{wr: wr_q, addr: addr_q, data: data_q};
  assign file_rd = rd_q;
  assign cfg_value = cfg_q;
  assign global_irq_enable_set = irq_en_q;
  // Forced enable bit while the set pulse stands
  assign global_irq_enable_mask = irq_en_q ? (interrupt_control_register | (8'h01 << `MRCD_IRQ_ENABLE_BIT))
                                           : interrupt_control_register;
  assign phase = phase_q;
  assign op = op_q;

  // Checks
  sequence s_iret_taken;
    instr_valid && !busy && (instr_word == `MRCD_IRET_CODE);
  endsequence

  sequence s_store_taken;
    instr_valid && !busy && (decode(instr_word) == MRCD_OP_STORE);
  endsequence

  a_store_write_phase: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ1
    s_store_taken |-> ##3 (file_wr.wr && file_wr.addr == $past(instr_word[6:0], 3) && file_wr.data == $past(acc_value, 1)))
    else $error("store did not write accumulator in phase four");

  a_store_read_phase: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ10
    s_store_taken |-> ##1 file_rd ##1 !file_rd)
    else $error("store read not in phase two");

  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ2
    (op == MRCD_OP_IDLE) |-> (!file_wr.wr && !stack_pop && !global_irq_enable_set &&
      ($stable(cfg_value) || $past(cfg_file_wr))))
    else $error("idle changed state");

  a_idle_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ3
    (instr_valid && !busy && decode(instr_word) == MRCD_OP_IDLE) |-> ##1 busy [*3] ##1 !busy)
    else $error("idle not one instruction cycle");

  a_iret_gie_phase: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ11
    s_iret_taken |-> ##2 (global_irq_enable_set && !stack_pop) ##1 (stack_pop && !global_irq_enable_set))
    else $error("interrupt return phase order wrong");

  a_iret_pc_load: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ4
    s_iret_taken |-> ##3 (pc_load && pc_value == $past(stack_top_entry, 1)))
    else $error("counter not loaded from stack top");

  a_iret_gie_bit: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ5
    global_irq_enable_set |-> global_irq_enable_mask[`MRCD_IRQ_ENABLE_BIT])
    else $error("global enable not set");

  a_iret_two_cycles: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ6
    s_iret_taken |-> ##4 (busy && !stack_pop && !global_irq_enable_set && !file_wr.wr) [*4] ##1 !busy)
    else $error("second cycle not idle");

  a_cfg_load: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ7
    (instr_valid && !busy && instr_word == `MRCD_CFG_CODE && !cfg_file_wr) ##1 !cfg_file_wr [*3]
      |-> ##1 (cfg_value == $past(acc_value, 2)))
    else $error("config not loaded from accumulator");

  a_cfg_direct: assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ8
    (cfg_file_wr && op != MRCD_OP_CFG) |=> (cfg_value == $past(cfg_file_wdata)))
    else $error("direct config write lost");

endmodule // mrcd_core
`default_nettype wire

/* File: hdl/mrcd_defines.svh */
// Constants for the move/return/config instruction decoder.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef MRCD_DEFINES_SVH
`define MRCD_DEFINES_SVH
// Store accumulator: 00 0000 1fff ffff
`define MRCD_STORE_MASK 14'h3F80
`define MRCD_STORE_CODE 14'h0080
// Idle: 00 0000 0xx0 0000
`define MRCD_IDLE_MASK 14'h3F9F
`define MRCD_IDLE_CODE 14'h0000
// Interrupt return: 00 0000 0000 1001
`define MRCD_IRET_CODE 14'h0009
// Legacy configuration load: 00 0000 0110 0010
`define MRCD_CFG_CODE 14'h0062
// Global enable bit position in the interrupt control register
`define MRCD_IRQ_ENABLE_BIT 7
// Reset value of the timer configuration register
`define MRCD_CFG_RESET 8'hFF
`endif

/* File: hdl/mrcd_pkg.sv */
// Types for the move/return/config instruction decoder.
// Assumes the defines header is compiled alongside.
`default_nettype none
package mrcd_pkg;
  // Decoded instruction class
  typedef enum logic [2:0] {
    MRCD_OP_NONE,
    MRCD_OP_STORE,
    MRCD_OP_IDLE,
    MRCD_OP_IRET,
    MRCD_OP_CFG
  } mrcd_op_t;
  // Request towards the register file
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } mrcd_file_wr_t;
endpackage
`default_nettype wire
